// File: rtl/wdt_map.svh
/*
 * Address map, key bytes, field positions, reset values and timing counts
 * of the watchdog / interval timer.
 * Assumes inclusion by bare name from any design or bench file.
 */
`ifndef WDT_MAP_SVH
`define WDT_MAP_SVH

// ----------------------------------------------------------------------
// Addresses
// ----------------------------------------------------------------------
`define WDT_ADDR_TCS_WR 32'hFFFF8610
`define WDT_ADDR_TCS_RD 32'hFFFF8610
`define WDT_ADDR_CNT_RD 32'hFFFF8611
`define WDT_ADDR_RCS_WR 32'hFFFF8612
`define WDT_ADDR_RCS_RD 32'hFFFF8613

// ----------------------------------------------------------------------
// Write keys (upper byte of a word write) and flag clear data (lower byte)
// ----------------------------------------------------------------------
`define WDT_KEY_LOAD 8'h5A
`define WDT_KEY_CTRL 8'hA5
`define WDT_FLAG_CLR_DATA 8'h00

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define WDT_TCS_FLAG_BIT 7
`define WDT_TCS_MODE_BIT 6
`define WDT_TCS_ENA_BIT 5
`define WDT_TCS_CKS_MSB 2
`define WDT_TCS_CKS_LSB 0
`define WDT_RCS_FLAG_BIT 7
`define WDT_RCS_RENA_BIT 6
`define WDT_RCS_RTYP_BIT 5

// ----------------------------------------------------------------------
// Reset values, fixed read bits and counter maximum
// ----------------------------------------------------------------------
`define WDT_TCS_RESET 8'h18
`define WDT_CNT_RESET 8'h00
`define WDT_RCS_RESET 8'h1F
`define WDT_TCS_FIXED 8'h18
`define WDT_RCS_FIXED 8'h1F
`define WDT_CNT_MAX 8'hFF

// ----------------------------------------------------------------------
// Timing counts in mclk cycles and prescaler width in bits
// ----------------------------------------------------------------------
`define WDT_PIN_OUT_CYCLES 8'h80
`define WDT_RST_OUT_CYCLES 10'h200
`define WDT_PRESCALE_WIDTH 13

`endif

// File: rtl/wdt_pkg.sv
/*
 * Types shared by the watchdog / interval timer and its bench.
 * Assumes nothing of its surroundings.
 */
package wdt_pkg;

  // ----------------------------------------------------------------------
  // Bus access
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    WDT_SIZE_BYTE,
    WDT_SIZE_WORD,
    WDT_SIZE_LONG
  } wdt_size_e;

  typedef struct packed {
    logic wr;
    wdt_size_e size;
    logic [31:0] addr;
    logic [15:0] wdata;
  } wdt_bus_req_s;

  typedef enum logic [1:0] {
    WDT_BUS_IDLE,
    WDT_BUS_WAIT1,
    WDT_BUS_WAIT2
  } wdt_bus_state_e;

  typedef logic [2:0] wdt_cks_t;

endpackage

// File: rtl/wdt_prescaler.sv
/*
 * Free-running prescaler producing one-cycle tick pulses at the selected
 * divide ratio of mclk.
 * Assumes a single clock domain and a synchronous active-high reset.
 */
`timescale 1ns/1ns
`include "wdt_map.svh"

module wdt_prescaler #(
  parameter int WIDTH = `WDT_PRESCALE_WIDTH
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire wdt_pkg::wdt_cks_t clock_select,
  output logic tick
);

  logic [WIDTH-1:0] div_reg;
  logic [WIDTH-1:0] div_next;
  logic tick_reg;
  logic tick_next;
  logic [WIDTH-1:0] mask;

  // ----------------------------------------------------------------------
  // Select code to divide exponent
  // ----------------------------------------------------------------------
  function automatic logic [3:0] div_shift(input wdt_pkg::wdt_cks_t sel);
    case (sel)
      3'h0: div_shift = 4'h1;
      3'h1: div_shift = 4'h6;
      3'h2: div_shift = 4'h7;
      3'h3: div_shift = 4'h8;
      3'h4: div_shift = 4'h9;
      3'h5: div_shift = 4'hA;
      3'h6: div_shift = 4'hC;
      default: div_shift = 4'hD;
    endcase
  endfunction

  always_comb begin
    mask = (WIDTH'(1) << div_shift(clock_select)) - WIDTH'(1);
    div_next = div_reg + WIDTH'(1);
    tick_next = ((div_reg & mask) == mask);
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      div_reg <= '0;
      tick_reg <= 1'b0;
    end else begin
      div_reg <= div_next;
      tick_reg <= tick_next;
    end
  end

  assign tick = tick_reg;

endmodule

// File: rtl/wdt_timer.sv
/*
 * Watchdog / interval timer: 8-bit counter, control/status and reset
 * control registers behind keyed word writes and byte reads, overflow
 * pin pulse, internal reset pulse and interval interrupt.
 * Assumes synchronous bus inputs on mclk and one access at a time.
 */
// What this block does
// - 8-bit up counter, ticks while enabled
// - Wrap FF to 00 raises pin or interrupt
// - Counter clears on power-on, kept in standby
// - Flag, mode, enable clear on reset and standby
// - Clock select clears except in software standby
// - Interval flag set only by interval overflow
// - Interval flag cleared by writing zero after reading it as one, or by reset or standby
// - Mode 0 interval, mode 1 watchdog
// - Enable low holds counter at zero, except during standby where it keeps its value
// - Bits 4 and 3 read as one
// - Eight divide ratios from 2 to 8192
// - Counter and control: keyed word writes only
// - Byte reads: TCS at its write address, CNT and RCS at separate read addresses
// - Every access takes three bus cycles
// - Watchdog overflow drives pin, optional reset
// - Key 5A loads counter, A5 loads control
// - Overflow pin low for 128 cycles
// - Internal reset 512 cycles, type selectable
// - Reset control keyed clear and load
`timescale 1ns/1ns
`include "wdt_map.svh"

module wdt_timer #(
  parameter int PRESCALE_WIDTH = `WDT_PRESCALE_WIDTH
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic hw_standby,
  input wire logic sw_standby,
  input wire logic bus_valid,
  input wire wdt_pkg::wdt_bus_req_s bus_req,
  output logic bus_ack,
  output logic [7:0] bus_rdata,
  output logic overflow_out_n,
  output logic interval_irq,
  output logic internal_reset,
  output logic reset_type_manual
);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  logic [7:0] wd_count_reg, wd_count_next;
  logic interval_flag_reg, interval_flag_next;
  logic mode_select_reg, mode_select_next;
  logic count_enable_reg, count_enable_next;
  wdt_pkg::wdt_cks_t clock_select_reg, clock_select_next;
  logic watchdog_flag_reg, watchdog_flag_next;
  logic internal_reset_enable_reg, internal_reset_enable_next;
  logic reset_type_select_reg, reset_type_select_next;
  logic iflag_seen_reg, iflag_seen_next;
  logic wflag_seen_reg, wflag_seen_next;
  logic [7:0] pin_cnt_reg, pin_cnt_next;
  logic [9:0] rst_cnt_reg, rst_cnt_next;
  logic overflow_out_n_reg, overflow_out_n_next;
  logic internal_reset_reg, internal_reset_next;
  logic reset_type_manual_reg, reset_type_manual_next;
  wdt_pkg::wdt_bus_state_e bus_state_reg, bus_state_next;
  wdt_pkg::wdt_bus_req_s req_reg, req_next;
  logic bus_ack_reg, bus_ack_next;
  logic [7:0] bus_rdata_reg, bus_rdata_next;

  logic tick;
  logic overflow;
  logic wd_overflow;
  logic it_overflow;
  logic do_access;
  logic word_wr;
  logic byte_rd;
  logic [7:0] key;
  logic [7:0] wlo;
  logic [7:0] tcs_view;
  logic [7:0] rcs_view;

  // ----------------------------------------------------------------------
  // Prescaler
  // ----------------------------------------------------------------------
  wdt_prescaler #(
    .WIDTH(PRESCALE_WIDTH)
  ) u_prescaler (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .clock_select(clock_select_reg),
    .tick(tick)
  );

  // ----------------------------------------------------------------------
  // Register views
  // ----------------------------------------------------------------------
  always_comb begin
    tcs_view = `WDT_TCS_FIXED;
    tcs_view[`WDT_TCS_FLAG_BIT] = interval_flag_reg;
    tcs_view[`WDT_TCS_MODE_BIT] = mode_select_reg;
    tcs_view[`WDT_TCS_ENA_BIT] = count_enable_reg;
    tcs_view[`WDT_TCS_CKS_MSB:`WDT_TCS_CKS_LSB] = clock_select_reg;
    rcs_view = `WDT_RCS_FIXED;
    rcs_view[`WDT_RCS_FLAG_BIT] = watchdog_flag_reg;
    rcs_view[`WDT_RCS_RENA_BIT] = internal_reset_enable_reg;
    rcs_view[`WDT_RCS_RTYP_BIT] = reset_type_select_reg;
  end

  // ----------------------------------------------------------------------
  // Bus sequencing
  // ----------------------------------------------------------------------
  always_comb begin
    bus_state_next = bus_state_reg;
    req_next = req_reg;
    bus_ack_next = 1'b0;
    bus_rdata_next = bus_rdata_reg;
    do_access = 1'b0;
    case (bus_state_reg)
      wdt_pkg::WDT_BUS_IDLE: begin
        if (bus_valid) begin
          req_next = bus_req;
          bus_state_next = wdt_pkg::WDT_BUS_WAIT1;
        end
      end
      wdt_pkg::WDT_BUS_WAIT1: begin
        bus_state_next = wdt_pkg::WDT_BUS_WAIT2;
      end
      wdt_pkg::WDT_BUS_WAIT2: begin
        do_access = 1'b1;
        bus_ack_next = 1'b1;
        bus_state_next = wdt_pkg::WDT_BUS_IDLE;
        bus_rdata_next = 8'h00;
        if (!req_reg.wr && req_reg.size == wdt_pkg::WDT_SIZE_BYTE) begin
          case (req_reg.addr)
            `WDT_ADDR_TCS_RD: bus_rdata_next = tcs_view;
            `WDT_ADDR_CNT_RD: bus_rdata_next = wd_count_reg;
            `WDT_ADDR_RCS_RD: bus_rdata_next = rcs_view;
            default: bus_rdata_next = 8'h00;
          endcase
        end
      end
      default: begin
        bus_state_next = wdt_pkg::WDT_BUS_IDLE;
      end
    endcase
    word_wr = do_access && req_reg.wr &&
              req_reg.size == wdt_pkg::WDT_SIZE_WORD;
    byte_rd = do_access && !req_reg.wr &&
              req_reg.size == wdt_pkg::WDT_SIZE_BYTE;
    key = req_reg.wdata[15:8];
    wlo = req_reg.wdata[7:0];
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      bus_state_reg <= wdt_pkg::WDT_BUS_IDLE;
      req_reg <= '0;
      bus_ack_reg <= 1'b0;
      bus_rdata_reg <= 8'h00;
    end else begin
      bus_state_reg <= bus_state_next;
      req_reg <= req_next;
      bus_ack_reg <= bus_ack_next;
      bus_rdata_reg <= bus_rdata_next;
    end
  end

  // ----------------------------------------------------------------------
  // Counter and timer control/status
  // ----------------------------------------------------------------------
  always_comb begin
    overflow = tick && count_enable_reg &&
               wd_count_reg == `WDT_CNT_MAX;
    wd_overflow = overflow && mode_select_reg;
    it_overflow = overflow && !mode_select_reg;
    wd_count_next = wd_count_reg;
    interval_flag_next = interval_flag_reg;
    mode_select_next = mode_select_reg;
    count_enable_next = count_enable_reg;
    clock_select_next = clock_select_reg;
    iflag_seen_next = iflag_seen_reg;
    if (count_enable_reg && tick) begin
      wd_count_next = wd_count_reg + 8'h01;
    end
    if (byte_rd && req_reg.addr == `WDT_ADDR_TCS_RD &&
        interval_flag_reg) begin
      iflag_seen_next = 1'b1;
    end
    if (word_wr && req_reg.addr == `WDT_ADDR_TCS_WR) begin
      if (key == `WDT_KEY_LOAD) begin
        wd_count_next = wlo;
      end else if (key == `WDT_KEY_CTRL) begin
        mode_select_next = wlo[`WDT_TCS_MODE_BIT];
        count_enable_next = wlo[`WDT_TCS_ENA_BIT];
        clock_select_next = wlo[`WDT_TCS_CKS_MSB:`WDT_TCS_CKS_LSB];
        if (!wlo[`WDT_TCS_FLAG_BIT] && iflag_seen_reg) begin
          interval_flag_next = 1'b0;
          iflag_seen_next = 1'b0;
        end
      end
    end
    if (wd_overflow) begin
      wd_count_next = `WDT_CNT_RESET;
      mode_select_next = 1'b0;
      count_enable_next = 1'b0;
      clock_select_next = 3'h0;
    end
    if (it_overflow) begin
      interval_flag_next = 1'b1;
    end
    if (!count_enable_next) begin
      wd_count_next = `WDT_CNT_RESET;
    end
    if (hw_standby || sw_standby) begin
      wd_count_next = wd_count_reg;
      interval_flag_next = 1'b0;
      mode_select_next = 1'b0;
      count_enable_next = 1'b0;
      iflag_seen_next = 1'b0;
    end
    if (hw_standby) begin
      clock_select_next = 3'h0;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      wd_count_reg <= `WDT_CNT_RESET;
      interval_flag_reg <= 1'b0;
      mode_select_reg <= 1'b0;
      count_enable_reg <= 1'b0;
      clock_select_reg <= 3'h0;
      iflag_seen_reg <= 1'b0;
    end else begin
      wd_count_reg <= wd_count_next;
      interval_flag_reg <= interval_flag_next;
      mode_select_reg <= mode_select_next;
      count_enable_reg <= count_enable_next;
      clock_select_reg <= clock_select_next;
      iflag_seen_reg <= iflag_seen_next;
    end
  end

  // ----------------------------------------------------------------------
  // Reset control/status
  // ----------------------------------------------------------------------
  always_comb begin
    watchdog_flag_next = watchdog_flag_reg;
    internal_reset_enable_next = internal_reset_enable_reg;
    reset_type_select_next = reset_type_select_reg;
    wflag_seen_next = wflag_seen_reg;
    if (byte_rd && req_reg.addr == `WDT_ADDR_RCS_RD &&
        watchdog_flag_reg) begin
      wflag_seen_next = 1'b1;
    end
    if (word_wr && req_reg.addr == `WDT_ADDR_RCS_WR) begin
      if (key == `WDT_KEY_CTRL && wlo == `WDT_FLAG_CLR_DATA &&
          wflag_seen_reg) begin
        watchdog_flag_next = 1'b0;
        wflag_seen_next = 1'b0;
      end else if (key == `WDT_KEY_LOAD) begin
        internal_reset_enable_next = wlo[`WDT_RCS_RENA_BIT];
        reset_type_select_next = wlo[`WDT_RCS_RTYP_BIT];
      end
    end
    if (wd_overflow) begin
      watchdog_flag_next = 1'b1;
    end
    if (hw_standby || sw_standby) begin
      watchdog_flag_next = 1'b0;
      internal_reset_enable_next = 1'b0;
      reset_type_select_next = 1'b0;
      wflag_seen_next = 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      watchdog_flag_reg <= 1'b0;
      internal_reset_enable_reg <= 1'b0;
      reset_type_select_reg <= 1'b0;
      wflag_seen_reg <= 1'b0;
    end else begin
      watchdog_flag_reg <= watchdog_flag_next;
      internal_reset_enable_reg <= internal_reset_enable_next;
      reset_type_select_reg <= reset_type_select_next;
      wflag_seen_reg <= wflag_seen_next;
    end
  end

  // ----------------------------------------------------------------------
  // Overflow pin and internal reset pulses
  // ----------------------------------------------------------------------
  always_comb begin
    pin_cnt_next = pin_cnt_reg;
    rst_cnt_next = rst_cnt_reg;
    reset_type_manual_next = reset_type_manual_reg;
    if (pin_cnt_reg != 8'h00) begin
      pin_cnt_next = pin_cnt_reg - 8'h01;
    end
    if (rst_cnt_reg != 10'h000) begin
      rst_cnt_next = rst_cnt_reg - 10'h001;
    end
    if (wd_overflow) begin
      pin_cnt_next = `WDT_PIN_OUT_CYCLES;
      if (internal_reset_enable_reg) begin
        rst_cnt_next = `WDT_RST_OUT_CYCLES;
        reset_type_manual_next = reset_type_select_reg;
      end
    end
    overflow_out_n_next = (pin_cnt_next == 8'h00);
    internal_reset_next = (rst_cnt_next != 10'h000);
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      pin_cnt_reg <= 8'h00;
      rst_cnt_reg <= 10'h000;
      overflow_out_n_reg <= 1'b1;
      internal_reset_reg <= 1'b0;
      reset_type_manual_reg <= 1'b0;
    end else begin
      pin_cnt_reg <= pin_cnt_next;
      rst_cnt_reg <= rst_cnt_next;
      overflow_out_n_reg <= overflow_out_n_next;
      internal_reset_reg <= internal_reset_next;
      reset_type_manual_reg <= reset_type_manual_next;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign bus_ack = bus_ack_reg;
  assign bus_rdata = bus_rdata_reg;
  assign overflow_out_n = overflow_out_n_reg;
  assign interval_irq = interval_flag_reg;
  assign internal_reset = internal_reset_reg;
  assign reset_type_manual = reset_type_manual_reg;

endmodule

// File: verification/wdt_timer_monitor.sv
/*
 * Checker for the watchdog / interval timer ports.
 * Assumes binding to wdt_timer, one mclk domain, sync sys_rst.
 */
`timescale 1ns/1ns
`include "wdt_map.svh"
module wdt_timer_monitor #(
  parameter int PRESCALE_WIDTH = 13
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic hw_standby,
  input wire logic sw_standby,
  input wire logic bus_valid,
  input wire wdt_pkg::wdt_bus_req_s bus_req,
  input wire logic bus_ack,
  input wire logic [7:0] bus_rdata,
  input wire logic overflow_out_n,
  input wire logic interval_irq,
  input wire logic internal_reset,
  input wire logic reset_type_manual
);
  // ----------------------------------------------------------------
  // Access phase, taken request and pulse lengths
  // ----------------------------------------------------------------
  logic [1:0] ph_reg, ph_next;
  wdt_pkg::wdt_bus_req_s req_reg, req_next;
  logic [7:0] lo_reg, lo_next;
  logic [9:0] hi_reg, hi_next;
  logic rd_ack;
  always_comb begin
    case (ph_reg)
      2'h0: ph_next = {1'b0, bus_valid};
      2'h1: ph_next = 2'h2;
      default: ph_next = 2'h0;
    endcase
    req_next = (ph_reg == 2'h0 && bus_valid) ? bus_req : req_reg;
    lo_next = overflow_out_n ? 8'h00 : lo_reg + {7'h00, lo_reg != 8'hFF};
    hi_next = internal_reset ? hi_reg + {9'h000, hi_reg != 10'h3FF} : 10'h000;
    rd_ack = bus_ack && !req_reg.wr;
  end
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      ph_reg <= 2'h0;
      req_reg <= '0;
      lo_reg <= 8'h00;
      hi_reg <= 10'h000;
    end else begin
      ph_reg <= ph_next;
      req_reg <= req_next;
      lo_reg <= lo_next;
      hi_reg <= hi_next;
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  a_ack_timing: assert property (ph_reg == 2'h0 && bus_valid
    |=> !bus_ack ##1 !bus_ack ##1 bus_ack) else $error("late ack");
  a_ack_cause: assert property (bus_ack |-> $past(ph_reg) == 2'h2)
    else $error("stray ack");
  a_tcs_fixed: assert property (rd_ack && req_reg.addr ==
    `WDT_ADDR_TCS_RD && req_reg.size == wdt_pkg::WDT_SIZE_BYTE
    |-> bus_rdata[4:3] == 2'h3) else $error("tcs bits 4:3 not one");
  a_rcs_fixed: assert property (rd_ack && req_reg.addr ==
    `WDT_ADDR_RCS_RD && req_reg.size == wdt_pkg::WDT_SIZE_BYTE
    |-> bus_rdata[4:0] == 5'h1F) else $error("rcs low bits wrong");
  a_bad_read: assert property (rd_ack &&
    req_reg.size != wdt_pkg::WDT_SIZE_BYTE |-> bus_rdata == 8'h00)
    else $error("non-byte read gave data");
  a_pin_width: assert property ($rose(overflow_out_n) &&
    !$past(sys_rst) |-> lo_reg == 8'h80) else $error("pin pulse width");
  a_pin_bound: assert property (!overflow_out_n |-> lo_reg < 8'h80)
    else $error("pin pulse too long");
  a_rst_width: assert property ($fell(internal_reset) &&
    !$past(sys_rst) |-> hi_reg == 10'h200) else $error("reset width");
  a_rst_with_pin: assert property ($rose(internal_reset)
    |-> $fell(overflow_out_n)) else $error("reset without pin");
  a_irq_clear: assert property ($fell(interval_irq) |-> bus_ack ||
    $past(sys_rst) || $past(hw_standby) || $past(sw_standby))
    else $error("flag dropped by itself");
  a_pin_no_irq: assert property ($fell(overflow_out_n)
    |-> !$rose(interval_irq)) else $error("flag set in watchdog");
endmodule

// File: verification/wdt_reset_sink.sv
/*
 * External reset circuitry model: measures pin and reset pulses.
 * Assumes the timer's mclk and its registered pulse outputs.
 */
`timescale 1ns/1ns
module wdt_reset_sink (
  input wire logic mclk,
  input wire logic overflow_out_n,
  input wire logic internal_reset,
  input wire logic reset_type_manual,
  output int pin_len,
  output int rst_len,
  output logic type_manual
);
  int pin_run = 0;
  int rst_run = 0;
  initial pin_len = 0;
  initial rst_len = 0;
  initial type_manual = 1'b0;
  always @(posedge mclk) begin
    if (overflow_out_n === 1'b0) begin
      pin_run <= pin_run + 1;
    end else begin
      if (pin_run != 0) pin_len <= pin_run;
      pin_run <= 0;
    end
    if (internal_reset === 1'b1) begin
      rst_run <= rst_run + 1;
      type_manual <= reset_type_manual;
    end else begin
      if (rst_run != 0) rst_len <= rst_run;
      rst_run <= 0;
    end
  end
endmodule

// File: verification/test_watchdog_interval_timer.sv
/*
 * Self-checking bench for the timer: register tasks and scenarios.
 * Assumes the design package, the map header and the sink model.
 */
`timescale 1ns/1ns
`include "wdt_map.svh"
module test_watchdog_interval_timer;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic hw_standby = 1'b0;
  logic sw_standby = 1'b0;
  logic bus_valid = 1'b0;
  wdt_pkg::wdt_bus_req_s bus_req = '0;
  logic bus_ack, overflow_out_n, interval_irq;
  logic internal_reset, reset_type_manual, type_manual;
  logic [7:0] bus_rdata;
  int pin_len, rst_len;
  int fails = 0;
  int n_compared = 0;
  int cyc = 0;
  localparam logic [31:0] TCS = `WDT_ADDR_TCS_WR;
  localparam logic [31:0] CNT = `WDT_ADDR_CNT_RD;
  localparam logic [31:0] RCW = `WDT_ADDR_RCS_WR;
  localparam logic [31:0] RCR = `WDT_ADDR_RCS_RD;
  initial forever #5 mclk = ~mclk;
  always @(posedge mclk) cyc <= cyc + 1;
  wdt_timer DUT (.mclk(mclk), .sys_rst(sys_rst), .hw_standby(hw_standby),
    .sw_standby(sw_standby), .bus_valid(bus_valid), .bus_req(bus_req),
    .bus_ack(bus_ack), .bus_rdata(bus_rdata),
    .overflow_out_n(overflow_out_n), .interval_irq(interval_irq),
    .internal_reset(internal_reset),
    .reset_type_manual(reset_type_manual));
  wdt_reset_sink SINK (.mclk(mclk), .overflow_out_n(overflow_out_n),
    .internal_reset(internal_reset), .reset_type_manual(reset_type_manual),
    .pin_len(pin_len), .rst_len(rst_len), .type_manual(type_manual));
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic tally_and_finish();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [15:0] e,
                     input logic [15:0] got);
    n_compared++;
    if (got !== e) begin
      fails++;
      $display("ERROR %s expected %h seen %h", what, e, got);
    end
  endtask
  task automatic acc(input logic w, input wdt_pkg::wdt_size_e s,
    input logic [31:0] a, input logic [15:0] d, output logic [7:0] q);
    int n;
    bus_req <= '{wr: w, size: s, addr: a, wdata: d};
    bus_valid <= 1'b1;
    @(posedge mclk);
    bus_valid <= 1'b0;
    n = 0;
    while (bus_ack !== 1'b1) begin
      @(posedge mclk);
      n++;
      if (n > 8) begin
        chk("bus ack", 16'h0001, 16'h0000);
        tally_and_finish();
      end
    end
    q = bus_rdata;
  endtask
  task automatic wr(input logic [31:0] a, input logic [7:0] k,
                    input logic [7:0] d);
    logic [7:0] q;
    acc(1'b1, wdt_pkg::WDT_SIZE_WORD, a, {k, d}, q);
  endtask
  task automatic rd(input logic [31:0] a, input logic [7:0] e,
                    input string what);
    logic [7:0] q;
    acc(1'b0, wdt_pkg::WDT_SIZE_BYTE, a, 16'h0000, q);
    chk(what, {8'h00, e}, {8'h00, q});
  endtask
  // Sel 0 flag up, 1 pin low, 2 both pulses over
  task automatic wait_for(input int sel, input int lim);
    int n;
    n = 0;
    while (!((sel == 0 && interval_irq === 1'b1) ||
             (sel == 1 && overflow_out_n === 1'b0) ||
             (sel == 2 && internal_reset === 1'b0 &&
              overflow_out_n === 1'b1))) begin
      @(posedge mclk);
      n++;
      if (n > lim) begin
        chk("wait done", 16'h0001, 16'h0000);
        tally_and_finish();
      end
    end
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    logic [7:0] q;
    int t0;
    int dv [8];
    dv = '{2, 64, 128, 256, 512, 1024, 4096, 8192};
    repeat (10) @(posedge mclk);
    sys_rst <= 1'b0;
    rd(TCS, 8'h18, "tcs reset");
    rd(CNT, 8'h00, "cnt reset");
    rd(RCR, 8'h1F, "rcs reset");
    wr(TCS, 8'hA5, 8'h3F);
    wr(TCS, 8'h5A, 8'h42);
    rd(CNT, 8'h42, "cnt load");
    acc(1'b1, wdt_pkg::WDT_SIZE_BYTE, TCS, 16'h5A10, q);
    acc(1'b1, wdt_pkg::WDT_SIZE_LONG, TCS, 16'h5A10, q);
    wr(TCS, 8'h12, 8'h10);
    rd(CNT, 8'h42, "cnt bad write");
    acc(1'b0, wdt_pkg::WDT_SIZE_WORD, CNT, 16'h0000, q);
    chk("word read", 16'h0000, {8'h00, q});
    rd(32'hFFFF8620, 8'h00, "unmapped");
    wr(TCS, 8'hA5, 8'h1F);
    rd(CNT, 8'h00, "cnt stop");
    rd(TCS, 8'h1F, "tcs load");
    for (int c = 1; c < 8; c++) begin
      wr(TCS, 8'hA5, 8'h38 | c);
      wr(TCS, 8'h5A, 8'hFF);
      wait_for(0, 8300);
      t0 = cyc;
      rd(TCS, 8'hB8 | c, "flag set");
      wr(TCS, 8'h5A, 8'hFF);
      wr(TCS, 8'hA5, 8'h38 | c);
      chk("irq clear", 16'h0000, {15'h0, interval_irq});
      wait_for(0, 8300);
      chk("tick ratio", 16'(dv[c]), 16'(cyc - t0));
      rd(TCS, 8'hB8 | c, "flag seen");
      wr(TCS, 8'hA5, 8'hB8 | c);
      rd(TCS, 8'hB8 | c, "flag write one");
      wr(TCS, 8'hA5, 8'h18 | c);
      rd(TCS, 8'h18 | c, "flag clear");
    end
    for (int t = 0; t < 2; t++) begin
      wr(RCW, 8'h5A, t ? 8'h60 : 8'h40);
      rd(RCR, t ? 8'h7F : 8'h5F, "rcs load");
      wr(TCS, 8'hA5, 8'h78);
      wr(TCS, 8'h5A, 8'hFF);
      wait_for(1, 40);
      wait_for(2, 600);
      @(posedge mclk);
      chk("pin len", 16'h0080, 16'(pin_len));
      chk("rst len", 16'h0200, 16'(rst_len));
      chk("rst type", 16'(t), {15'h0, type_manual});
      chk("no irq", 16'h0000, {15'h0, interval_irq});
      rd(TCS, 8'h18, "tcs after wd");
      rd(RCR, t ? 8'hFF : 8'hDF, "wd flag");
      wr(RCW, 8'hA5, 8'h00);
      rd(RCR, t ? 8'h7F : 8'h5F, "wd flag clear");
    end
    wr(RCW, 8'h5A, 8'h00);
    wr(TCS, 8'hA5, 8'h78);
    wr(TCS, 8'h5A, 8'hFF);
    wait_for(1, 40);
    chk("no rst", 16'h0000, {15'h0, internal_reset});
    wait_for(2, 600);
    rd(RCR, 8'h9F, "wd flag only");
    wr(RCW, 8'hA5, 8'h00);
    wr(TCS, 8'hA5, 8'h3D);
    sw_standby <= 1'b1;
    @(posedge mclk);
    sw_standby <= 1'b0;
    rd(TCS, 8'h1D, "sw standby");
    rd(RCR, 8'h1F, "sw standby rcs");
    wr(TCS, 8'hA5, 8'h3D);
    wr(RCW, 8'h5A, 8'h60);
    hw_standby <= 1'b1;
    @(posedge mclk);
    hw_standby <= 1'b0;
    rd(TCS, 8'h18, "hw standby");
    rd(RCR, 8'h1F, "hw standby rcs");
    wr(TCS, 8'hA5, 8'h3D);
    wr(RCW, 8'h5A, 8'h40);
    sys_rst <= 1'b1;
    repeat (2) @(posedge mclk);
    sys_rst <= 1'b0;
    rd(TCS, 8'h18, "second reset");
    rd(CNT, 8'h00, "second reset cnt");
    rd(RCR, 8'h1F, "second reset rcs");
    tally_and_finish();
  end
endmodule
bind wdt_timer wdt_timer_monitor #(.PRESCALE_WIDTH(PRESCALE_WIDTH)) u_mon (
  .mclk(mclk), .sys_rst(sys_rst), .hw_standby(hw_standby),
  .sw_standby(sw_standby), .bus_valid(bus_valid), .bus_req(bus_req),
  .bus_ack(bus_ack), .bus_rdata(bus_rdata),
  .overflow_out_n(overflow_out_n), .interval_irq(interval_irq),
  .internal_reset(internal_reset), .reset_type_manual(reset_type_manual));
